// [test_timer16_control.sv]
// testbench: apb reads checked against a queue of expected values
`timescale 1ns/1ps
`default_nettype none
module test_timer16_control;
  import timer16_pkg::*;
  logic mclk = 0, reset = 1, pin = 0, xtal = 0, cap = 0, gate = 0;
  apb_req_t req = '0;
  apb_rsp_t rsp;
  logic [31:0] exp_q[$], d;
  logic [15:0] rv;
  int tol_q[$], n_fail = 0, compares = 0, cyc = 0;
  logic [7:0] tbl[10] = '{8'h41, 8'h45, 8'h51, 8'h61, 8'h71, 8'h11,
    8'h81, 8'h85, 8'h89, 8'hc1};
  timer16_control uut (.mclk(mclk), .reset(reset), .clk_en(1'b1),
    .apb_req(req), .apb_rsp(rsp), .ext_count_clock_pin(pin),
    .crystal_osc_clock(xtal), .cap_sense_oscillator(cap),
    .gate_in(gate), .lowpower_osc_enable(), .gate_toggle_q(),
    .count_value());
  initial forever #5 mclk = ~mclk;
  task automatic final_report();
    $display("compares %0d n_fail %0d", compares, n_fail);
    if (n_fail == 0 && compares > 0)
      $display("Finished cleanly");
    else
      $display("Finished with errors");
    $finish;
  endtask : final_report
  task automatic xfer(input logic w, input logic [3:0] a,
    input logic [31:0] v);
    req <= '{1'b1, 1'b0, w, a, v};
    @(posedge mclk);
    req.penable <= 1'b1;
    // pready falls on the completing edge, so look mid-cycle
    do @(negedge mclk); while (rsp.pready !== 1'b1);
    @(posedge mclk);
    req <= '0;
    @(posedge mclk);
  endtask : xfer
  task automatic rd(input logic [3:0] a, input logic [31:0] e, input int t);
    exp_q.push_back(e);
    tol_q.push_back(t);
    xfer(1'b0, a, '0);
  endtask : rd
  // pin 5, crystal 7, cap 9 rising edges
  task automatic pulses();
    for (int i = 0; i < 9; i++) begin
      pin <= i < 5;
      xtal <= i < 7;
      cap <= 1'b1;
      repeat ($urandom % 4 + 3) @(posedge mclk);
      {pin, xtal, cap} <= 3'h0;
      repeat ($urandom % 4 + 3) @(posedge mclk);
    end
  endtask : pulses
  // internal run spans about 75 edges, so allow a small slack
  task automatic phase(input logic [7:0] c, input bit g);
    int e = g ? 0 : c[7] ? (c[6] ? 9 : c[3] ? 7 : 5)
      : 75 / ((c[6] ? 1 : 4) << c[5:4]);
    xfer(1'b1, addr_count, '0);
    xfer(1'b1, addr_control, {24'h0, c});
    if (c[7]) pulses();
    else repeat (64) @(posedge mclk);
    repeat (8) @(posedge mclk);
    xfer(1'b1, addr_control, {24'h0, c & 8'hfe});
    rd(addr_count, e, (c[7] || g) ? 0 : 2);
  endtask : phase
  // read data stands through the access cycle; sample it settled
  always @(negedge mclk) begin
    if (req.psel && req.penable && rsp.pready === 1'b1 && !req.pwrite) begin
      d = rsp.prdata - exp_q[0];
      compares++;
      if ((d <= tol_q[0] || -d <= tol_q[0]) !== 1'b1) begin
        n_fail++;
        $display("CHECK FAILED %0t got %h want %h", $time, rsp.prdata,
          exp_q[0]);
      end
      void'(exp_q.pop_front());
      void'(tol_q.pop_front());
    end
    if (++cyc == 9000) begin
      n_fail++;
      final_report();
    end
  end
  initial begin
    void'($urandom(98350));
    repeat (5) @(posedge mclk);
    reset <= 1'b0;
    @(posedge mclk);
    rd(addr_control, 32'h0, 0);
    rd(addr_gate_control, 32'h0, 0);
    xfer(1'b1, addr_control, 32'hfe);
    rd(addr_control, 32'hfc, 0);
    rv = 16'($urandom);
    xfer(1'b1, addr_count, {16'h0, rv});
    rd(addr_count, {16'h0, rv}, 0);
    foreach (tbl[i]) phase(tbl[i], 1'b0);
    xfer(1'b1, addr_gate_control, 32'h80);
    phase(8'h41, 1'b1);
    xfer(1'b1, addr_gate_control, 32'ha0);
    xfer(1'b1, addr_control, 32'h01);
    gate <= 1'b1;
    repeat (6) @(posedge mclk);
    gate <= 1'b0;
    repeat (6) @(posedge mclk);
    rd(addr_status, 32'h3, 0);
    xfer(1'b1, addr_control, 32'h00);
    rd(addr_status, 32'h0, 0);
    final_report();
  end
endmodule : test_timer16_control
`default_nettype wire

// [timer16_control.sv]
// 16-bit timer: clock select, prescale, sync, run and gate enable
`timescale 1ns/1ps
`default_nettype none
module timer16_control
  import timer16_pkg::*;
(
  // clock, reset, enable
  input wire logic mclk,
  input wire logic reset,
  input wire logic clk_en,
  // apb slave
  input wire timer16_pkg::apb_req_t apb_req,
  output var timer16_pkg::apb_rsp_t apb_rsp,
  // asynchronous count and gate sources
  input wire logic ext_count_clock_pin,
  input wire logic crystal_osc_clock,
  input wire logic cap_sense_oscillator,
  input wire logic gate_in,
  // to the oscillator and gate logic outside, plus the count value
  output logic lowpower_osc_enable,
  output logic gate_toggle_q,
  output logic [15:0] count_value
);
  import timer16_pkg::*;

  state_t s_reg;
  state_t s_next;

  logic [1:0] src;
  logic [1:0] psc_sel;
  logic run;
  logic sync_bypass;
  logic pin_edge;
  logic xtal_edge;
  logic cap_edge;
  logic gate_rise;
  logic gate_level;
  logic src_tick;
  logic psc_tick;
  logic gate_ok;
  logic count_inc;
  logic wr;
  logic rd;
  logic [31:0] rdata;
  logic known;

  always_comb begin
    s_next = s_reg;
    src = s_reg.control_reg[src_msb:src_lsb];
    psc_sel = s_reg.control_reg[psc_msb:psc_lsb];
    run = s_reg.control_reg[run_bit];
    sync_bypass = s_reg.control_reg[sync_dis_bit];
    wr = apb_req.psel && apb_req.penable && apb_req.pwrite;
    rd = apb_req.psel && apb_req.penable && !apb_req.pwrite;

    // two-stage synchronisers, second stage feeds edge logic and, for gate, the gate level
    s_next.pin_sync_reg = {s_reg.pin_sync_reg[0], ext_count_clock_pin};
    s_next.xtal_sync_reg = {s_reg.xtal_sync_reg[0], crystal_osc_clock};
    s_next.cap_sync_reg = {s_reg.cap_sync_reg[0], cap_sense_oscillator};
    s_next.gate_sync_reg = {s_reg.gate_sync_reg[0], gate_in};
    s_next.pin_last_reg = s_reg.pin_sync_reg[1];
    s_next.xtal_last_reg = s_reg.xtal_sync_reg[1];
    s_next.cap_last_reg = s_reg.cap_sync_reg[1];
    s_next.gate_last_reg = s_reg.gate_sync_reg[1];
    pin_edge = s_reg.pin_sync_reg[1] && !s_reg.pin_last_reg;
    xtal_edge = s_reg.xtal_sync_reg[1] && !s_reg.xtal_last_reg;
    cap_edge = s_reg.cap_sync_reg[1] && !s_reg.cap_last_reg;
    gate_rise = s_reg.gate_sync_reg[1] && !s_reg.gate_last_reg;

    // single clock domain: unsynchronised mode uses the same edge detect,
    // edge-history flop included; the two sync stages always stay
    s_next.div4_reg = s_reg.div4_reg + 2'h1;
    case (src)
      src_instr: src_tick = s_reg.div4_reg == div4_last;
      src_sys: src_tick = 1'b1;
      src_pin: begin
        if (s_reg.control_reg[osc_en_bit]) begin
          src_tick = xtal_edge;
        end else if (sync_bypass) begin
          src_tick = s_reg.pin_sync_reg[1] && !s_reg.pin_last_reg;
        end else begin
          src_tick = pin_edge;
        end
      end
      src_cap: src_tick = cap_edge;
      default: src_tick = 1'b0;
    endcase

    // prescaler: pulse on the wrap of the chosen low bits
    psc_tick = 1'b0;
    if (src_tick) begin
      s_next.psc_reg = s_reg.psc_reg + 3'h1;
      case (psc_sel)
        2'b00: psc_tick = 1'b1;
        2'b01: psc_tick = s_reg.psc_reg[0];
        2'b10: psc_tick = &s_reg.psc_reg[1:0];
        2'b11: psc_tick = &s_reg.psc_reg;
        default: psc_tick = 1'b0;
      endcase
    end
    if (!run) begin
      s_next.psc_reg = 3'h0;
    end

    // gate: toggle mode counts on the flop, else on the level
    if (!run || !s_reg.gate_reg[toggle_bit]) begin
      s_next.toggle_ff_reg = 1'b0;
    end else if (gate_rise) begin
      s_next.toggle_ff_reg = !s_reg.toggle_ff_reg;
    end
    gate_level = s_reg.gate_reg[toggle_bit] ? s_reg.toggle_ff_reg
                                              : s_reg.gate_sync_reg[1];
    gate_ok = !s_reg.gate_reg[gate_en_bit] || gate_level;
    count_inc = run && psc_tick && gate_ok;

    if (count_inc) begin
      s_next.count_reg = s_reg.count_reg + 16'h0001;
    end

    // apb: zero-wait answer, software write beats a count on collision
    s_next.rsp_reg.pready = apb_req.psel && !apb_req.penable;
    s_next.rsp_reg.pslverr = 1'b0;
    known = 1'b1;
    rdata = 32'h0000_0000;
    case (apb_req.paddr)
      addr_control: rdata = {24'h0, s_reg.control_reg & control_wmask};
      addr_gate_control: rdata = {24'h0, s_reg.gate_reg & gate_wmask};
      addr_count: rdata = {16'h0, s_reg.count_reg};
      addr_status: rdata = {30'h0, s_reg.toggle_ff_reg, gate_level};
      default: known = 1'b0;
    endcase
    if (apb_req.psel && !apb_req.penable) begin
      s_next.rsp_reg.prdata = rdata;
      s_next.rsp_reg.pslverr = !known;
    end
    if (rd || (wr && s_reg.rsp_reg.pready)) begin
      s_next.rsp_reg.pready = 1'b0;
    end
    if (wr && s_reg.rsp_reg.pready) begin
      case (apb_req.paddr)
        addr_control:
          s_next.control_reg = apb_req.pwdata[7:0] & control_wmask;
        addr_gate_control:
          s_next.gate_reg = apb_req.pwdata[7:0] & gate_wmask;
        addr_count: s_next.count_reg = apb_req.pwdata[15:0];
        default: s_next.count_reg = s_next.count_reg;
      endcase
    end
    s_next.osc_enable_reg = s_next.control_reg[osc_en_bit];
  end

  // reset stands for power-on/brown-out; no other reset exists here
  always_ff @(posedge mclk) begin
    if (reset) begin
      s_reg <= '0;
      s_reg.control_reg <= control_reset;
      s_reg.gate_reg <= gate_reset;
      s_reg.count_reg <= count_reset;
    end else if (clk_en) begin
      s_reg <= s_next;
    end
  end

  assign apb_rsp = s_reg.rsp_reg;
  assign lowpower_osc_enable = s_reg.osc_enable_reg;
  assign gate_toggle_q = s_reg.toggle_ff_reg;
  assign count_value = s_reg.count_reg;
endmodule : timer16_control
`default_nettype wire

// [timer16_control_sva.sv]
// checker: port assertions for the timer control block
`timescale 1ns/1ps
`default_nettype none
module timer16_control_sva
  import timer16_pkg::*;
(
  input wire logic mclk,
  input wire logic reset,
  input wire logic clk_en,
  input wire timer16_pkg::apb_req_t apb_req,
  input wire timer16_pkg::apb_rsp_t apb_rsp,
  input wire logic ext_count_clock_pin,
  input wire logic crystal_osc_clock,
  input wire logic cap_sense_oscillator,
  input wire logic gate_in,
  input wire logic lowpower_osc_enable,
  input wire logic gate_toggle_q,
  input wire logic [15:0] count_value
);
  logic [7:0] ctl_q;
  logic gen_q;
  wire logic acc = apb_req.psel && apb_req.penable && apb_rsp.pready;
  wire logic wr = acc && apb_req.pwrite;
  wire logic cwr = wr && apb_req.paddr == addr_count;
  wire logic on = ctl_q == 8'h41 && !gen_q && !cwr;
  always_ff @(posedge mclk) begin
    if (reset) begin
      ctl_q <= 8'h00;
      gen_q <= 1'b0;
    end else if (wr && apb_req.paddr == addr_control) begin
      ctl_q <= apb_req.pwdata[7:0];
    end else if (wr && apb_req.paddr == addr_gate_control) begin
      gen_q <= apb_req.pwdata[gate_en_bit];
    end
  end
  default clocking @(posedge mclk); endclocking
  default disable iff (reset);
  // three steady cycles hide any start-up lag of the tick
  sequence run_s;
    on [*3];
  endsequence
  ready_a: assert property (apb_req.psel && !apb_req.penable
    |=> apb_rsp.pready) else $error("no pready");
  pulse_a: assert property (apb_rsp.pready |=> !apb_rsp.pready)
    else $error("long pready");
  rst_zero_a: assert property (disable iff (1'b0) reset |=>
    count_value == '0 && !gate_toggle_q && !lowpower_osc_enable)
    else $error("reset value");
  rd_ctl_a: assert property (acc && !apb_req.pwrite &&
    apb_req.paddr == addr_control
    |-> apb_rsp.prdata == {24'h0, ctl_q & control_wmask})
    else $error("control read");
  osc_en_a: assert property (!wr [*2] |->
    lowpower_osc_enable == ctl_q[osc_en_bit]) else $error("osc enable");
  tog_clr_a: assert property (!ctl_q[run_bit] [*2] |-> !gate_toggle_q)
    else $error("toggle not cleared");
  stop_hold_a: assert property ((!ctl_q[run_bit] [*2]) ##0 !cwr
    |=> $stable(count_value)) else $error("count moved");
  sys_cnt_a: assert property (run_s
    |=> count_value == $past(count_value) + 16'h1) else $error("no tick");
endmodule : timer16_control_sva
bind timer16_control timer16_control_sva chk (.*);
`default_nettype wire

// [timer16_pkg.sv]
// package: register map, field positions and types for the 16-bit timer
package timer16_pkg;
  localparam logic [3:0] addr_control = 4'h0;
  localparam logic [3:0] addr_gate_control = 4'h4;
  localparam logic [3:0] addr_count = 4'h8;
  localparam logic [3:0] addr_status = 4'hc;
  localparam int src_msb = 7;
  localparam int src_lsb = 6;
  localparam int psc_msb = 5;
  localparam int psc_lsb = 4;
  localparam int osc_en_bit = 3;
  localparam int sync_dis_bit = 2;
  localparam int run_bit = 0;
  localparam int gate_en_bit = 7;
  localparam int toggle_bit = 5;
  localparam logic [7:0] control_reset = 8'h00;
  localparam logic [7:0] gate_reset = 8'h00;
  localparam logic [7:0] control_wmask = 8'hfd;
  localparam logic [7:0] gate_wmask = 8'ha0;
  localparam logic [15:0] count_reset = 16'h0000;
  localparam logic [1:0] div4_last = 2'h3;

  typedef enum logic [1:0] {
    src_instr = 2'b00,
    src_sys = 2'b01,
    src_pin = 2'b10,
    src_cap = 2'b11
  } clk_src_t;

  typedef struct packed {
    logic psel;
    logic penable;
    logic pwrite;
    logic [3:0] paddr;
    logic [31:0] pwdata;
  } apb_req_t;

  typedef struct packed {
    logic pready;
    logic [31:0] prdata;
    logic pslverr;
  } apb_rsp_t;

  typedef struct packed {
    logic [7:0] control_reg;
    logic [7:0] gate_reg;
    logic [15:0] count_reg;
    logic [1:0] div4_reg;
    logic [2:0] psc_reg;
    logic [1:0] pin_sync_reg;
    logic [1:0] xtal_sync_reg;
    logic [1:0] cap_sync_reg;
    logic [1:0] gate_sync_reg;
    logic pin_last_reg;
    logic xtal_last_reg;
    logic cap_last_reg;
    logic gate_last_reg;
    logic toggle_ff_reg;
    logic osc_enable_reg;
    apb_rsp_t rsp_reg;
  } state_t;
endpackage : timer16_pkg
